/* File: branch_condition.sv */
`default_nettype none
package carry_branch_pkg;
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_FLAGS = 8'h04;
	localparam logic [7:0] OFF_OPERAND = 8'h08;
	localparam logic [7:0] OFF_BITREG = 8'h0C;
	localparam logic [7:0] OFF_PC = 8'h10;
	localparam logic [7:0] OFF_TARGET = 8'h14;
	localparam logic [7:0] OFF_RET = 8'h18;
	localparam logic [7:0] OFF_STATUS = 8'h1C;
	localparam int CTRL_OP_LO = 0;
	localparam int CTRL_OP_HI = 4;
	localparam int CTRL_IMM_LO = 5;
	localparam int CTRL_IMM_HI = 7;
	localparam int CTRL_FROM_REG = 8;
	localparam int OP_BRANCH_BIT = 4;
	localparam int STATUS_TAKEN = 0;
	localparam int STATUS_REFUSED = 1;
	localparam logic [31:0] PC_RESET = 32'h0000_0000;
	typedef enum logic [4:0] {
		carry_xor_with_bit = 5'h00,
		carry_xor_with_inverted_bit = 5'h01,
		load_bit_into_carry = 5'h02,
		load_inverted_bit_into_carry = 5'h03,
		store_carry_into_bit = 5'h04,
		store_inverted_carry_into_bit = 5'h05,
		unconditional_goto = 5'h06,
		relative_subroutine_call = 5'h07,
		absolute_subroutine_call = 5'h08,
		subroutine_return = 5'h09
	} op_t;
	typedef enum logic [3:0] {
		unconditional_relative_goto = 4'h0,
		relative_never_taken = 4'h1,
		jump_if_higher = 4'h2,
		jump_if_lower_or_same = 4'h3,
		jump_if_carry_clear = 4'h4,
		jump_if_carry_set = 4'h5,
		jump_if_not_equal = 4'h6,
		jump_if_equal = 4'h7,
		jump_if_overflow_clear = 4'h8,
		jump_if_overflow_set = 4'h9,
		jump_if_plus = 4'hA,
		jump_if_minus = 4'hB,
		jump_if_greater_or_equal = 4'hC,
		jump_if_less_than = 4'hD,
		jump_if_greater_than = 4'hE,
		jump_if_less_or_equal = 4'hF
	} cond_t;
	typedef struct packed {
		logic n;
		logic z;
		logic v;
		logic c;
	} flags_t;
endpackage

module branch_condition (
	input wire logic [3:0] cond,
	input wire carry_branch_pkg::flags_t flags,
	output logic cond_true
);
	always_comb begin
		case (carry_branch_pkg::cond_t'(cond))
			carry_branch_pkg::unconditional_relative_goto: cond_true = 1'b1;
			carry_branch_pkg::relative_never_taken: cond_true = 1'b0;
			carry_branch_pkg::jump_if_higher: cond_true = ~(flags.c | flags.z);
			carry_branch_pkg::jump_if_lower_or_same: cond_true = flags.c | flags.z;
			carry_branch_pkg::jump_if_carry_clear: cond_true = ~flags.c;
			carry_branch_pkg::jump_if_carry_set: cond_true = flags.c;
			carry_branch_pkg::jump_if_not_equal: cond_true = ~flags.z;
			carry_branch_pkg::jump_if_equal: cond_true = flags.z;
			carry_branch_pkg::jump_if_overflow_clear: cond_true = ~flags.v;
			carry_branch_pkg::jump_if_overflow_set: cond_true = flags.v;
			carry_branch_pkg::jump_if_plus: cond_true = ~flags.n;
			carry_branch_pkg::jump_if_minus: cond_true = flags.n;
			carry_branch_pkg::jump_if_greater_or_equal: cond_true = ~(flags.n ^ flags.v);
			carry_branch_pkg::jump_if_less_than: cond_true = flags.n ^ flags.v;
			carry_branch_pkg::jump_if_greater_than: cond_true = ~(flags.z | (flags.n ^ flags.v));
			carry_branch_pkg::jump_if_less_or_equal: cond_true = flags.z | (flags.n ^ flags.v);
			default: cond_true = 1'b0;
		endcase
	end
	always_comb begin
		higher_cond_a: assert #0 (cond != 4'h2 || cond_true == ~(flags.c | flags.z))
			else $error("higher condition wrong");
		signed_ge_a: assert #0 (cond != 4'hC || cond_true == (flags.n == flags.v))
			else $error("greater or equal condition wrong");
		signed_le_a: assert #0 (cond != 4'hF || cond_true == (flags.z | (flags.n ^ flags.v)))
			else $error("less or equal condition wrong");
	end
endmodule
`default_nettype wire

/* File: carry_bit_ops_branch_cond.sv */
// Design decisions made here: the address map and the APB register port.
`default_nettype none
// What this block does
// - xor with bit: carry becomes carry xor selected operand bit.
// - xor with inverted bit: carry becomes carry xor complement of bit.
// - inverting bit forms take bit number only from the immediate field.
// - load bit: selected operand bit copied into carry.
// - load inverted bit: complement of selected bit copied into carry.
// - store: carry written into selected operand bit, other bits kept.
// - store inverted: complement of carry written into selected bit.
// - conditional branch goes to next plus target offset only when condition true, else next.
// - conditions: always, never, higher, lower-same, carry, zero, overflow, negative.
// - signed conditions from n xor v, and z or (n xor v).
// - non-inverting forms take bit number from immediate or register low bits.
module carry_bit_ops_branch_cond #(
	parameter int INSN_BYTES = 2
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [carry_branch_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr
);
	if (INSN_BYTES < 1 || INSN_BYTES > 16) begin : g_bad_step
		$error("INSN_BYTES out of range");
	end

	carry_branch_pkg::flags_t flags;
	logic [7:0] operand;
	logic [2:0] bitreg;
	logic [31:0] pc;
	logic [31:0] target;
	logic [31:0] ret_addr;
	logic taken;
	logic refused_flag;

	logic mapped;
	logic wr;
	logic exec;
	logic exec_ok;
	logic is_branch;
	carry_branch_pkg::op_t op;
	logic [2:0] bit_sel;
	logic bitv;
	logic from_reg;
	logic inv_form;
	logic known_op;
	logic refused;
	logic cond_true;
	logic [7:0] bit_mask;
	logic [31:0] step;
	logic [31:0] next_pc;
	logic [31:0] rel_target;
	logic [31:0] read_word;

	assign step = 32'(INSN_BYTES);
	assign next_pc = pc + step;
	assign rel_target = pc + step + target;
	assign pready = 1'b1;
	always_comb begin
		case (paddr)
			carry_branch_pkg::OFF_CTRL, carry_branch_pkg::OFF_FLAGS, carry_branch_pkg::OFF_OPERAND,
			carry_branch_pkg::OFF_BITREG, carry_branch_pkg::OFF_PC, carry_branch_pkg::OFF_TARGET,
			carry_branch_pkg::OFF_RET, carry_branch_pkg::OFF_STATUS: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	end
	assign pslverr = psel & penable & ~mapped;
	assign wr = psel & penable & pwrite & mapped;
	assign exec = wr && paddr == carry_branch_pkg::OFF_CTRL;

	assign op = carry_branch_pkg::op_t'(pwdata[carry_branch_pkg::CTRL_OP_HI:carry_branch_pkg::CTRL_OP_LO]);
	assign is_branch = pwdata[carry_branch_pkg::OP_BRANCH_BIT];
	assign from_reg = pwdata[carry_branch_pkg::CTRL_FROM_REG];
	assign bit_sel = from_reg ? bitreg : pwdata[carry_branch_pkg::CTRL_IMM_HI:carry_branch_pkg::CTRL_IMM_LO];
	assign bitv = operand[bit_sel];
	assign bit_mask = 8'h01 << bit_sel;
	assign inv_form = !is_branch && (op == carry_branch_pkg::carry_xor_with_inverted_bit
		|| op == carry_branch_pkg::load_inverted_bit_into_carry || op == carry_branch_pkg::store_inverted_carry_into_bit);
	assign known_op = is_branch || op <= carry_branch_pkg::subroutine_return;
	assign refused = (inv_form && from_reg) || !known_op;
	assign exec_ok = exec && !refused;

	branch_condition u_cond (
		.cond(pwdata[3:0]),
		.flags(flags),
		.cond_true(cond_true)
	);

	// carry and the other flags
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flags <= '0;
		end else if (exec_ok && !is_branch) begin
			case (op)
				carry_branch_pkg::carry_xor_with_bit: flags.c <= flags.c ^ bitv;
				carry_branch_pkg::carry_xor_with_inverted_bit: flags.c <= flags.c ^ ~bitv;
				carry_branch_pkg::load_bit_into_carry: flags.c <= bitv;
				carry_branch_pkg::load_inverted_bit_into_carry: flags.c <= ~bitv;
				default: flags.c <= flags.c;
			endcase
		end else if (wr && paddr == carry_branch_pkg::OFF_FLAGS) begin
			flags <= pwdata[3:0];
		end
	end

	// byte operand, target of the stores
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			operand <= 8'h00;
		end else if (exec_ok && !is_branch && op == carry_branch_pkg::store_carry_into_bit) begin
			operand <= (operand & ~bit_mask) | ({8{flags.c}} & bit_mask);
		end else if (exec_ok && !is_branch && op == carry_branch_pkg::store_inverted_carry_into_bit) begin
			operand <= (operand & ~bit_mask) | ({8{~flags.c}} & bit_mask);
		end else if (wr && paddr == carry_branch_pkg::OFF_OPERAND) begin
			operand <= pwdata[7:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bitreg <= 3'h0;
			target <= 32'h0000_0000;
		end else if (wr && paddr == carry_branch_pkg::OFF_BITREG) begin
			bitreg <= pwdata[2:0];
		end else if (wr && paddr == carry_branch_pkg::OFF_TARGET) begin
			target <= pwdata;
		end
	end

	// program counter
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pc <= carry_branch_pkg::PC_RESET;
		end else if (exec_ok && is_branch) begin
			pc <= cond_true ? rel_target : next_pc;
		end else if (exec_ok) begin
			case (op)
				carry_branch_pkg::unconditional_goto: pc <= target;
				carry_branch_pkg::relative_subroutine_call: pc <= rel_target;
				carry_branch_pkg::absolute_subroutine_call: pc <= target;
				carry_branch_pkg::subroutine_return: pc <= ret_addr;
				default: pc <= next_pc;
			endcase
		end else if (wr && paddr == carry_branch_pkg::OFF_PC) begin
			pc <= pwdata;
		end
	end

	// saved return address
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ret_addr <= 32'h0000_0000;
		end else if (exec_ok && !is_branch && (op == carry_branch_pkg::relative_subroutine_call
			|| op == carry_branch_pkg::absolute_subroutine_call)) begin
			ret_addr <= next_pc;
		end else if (wr && paddr == carry_branch_pkg::OFF_RET) begin
			ret_addr <= pwdata;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			taken <= 1'b0;
			refused_flag <= 1'b0;
		end else if (exec) begin
			taken <= exec_ok && (is_branch ? cond_true : op >= carry_branch_pkg::unconditional_goto);
			refused_flag <= refused;
		end
	end

	always_comb begin
		case (paddr)
			carry_branch_pkg::OFF_FLAGS: read_word = {28'h000_0000, flags};
			carry_branch_pkg::OFF_OPERAND: read_word = {24'h00_0000, operand};
			carry_branch_pkg::OFF_BITREG: read_word = {29'h0000_0000, bitreg};
			carry_branch_pkg::OFF_PC: read_word = pc;
			carry_branch_pkg::OFF_TARGET: read_word = target;
			carry_branch_pkg::OFF_RET: read_word = ret_addr;
			carry_branch_pkg::OFF_STATUS: read_word = {30'h0000_0000, refused_flag, taken};
			default: read_word = 32'h0000_0000;
		endcase
	end

	// read data sampled in the setup cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			prdata <= read_word;
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	xor_carry_a: assert property (exec_ok && !is_branch && op == carry_branch_pkg::carry_xor_with_bit
		|=> flags.c == ($past(flags.c) ^ $past(bitv))) else $error("xor carry wrong");
	xor_inv_carry_a: assert property (exec_ok && !is_branch && op == carry_branch_pkg::carry_xor_with_inverted_bit
		|=> flags.c == ($past(flags.c) ^ ~$past(bitv))) else $error("inverted xor carry wrong");
	inv_refuse_a: assert property (exec && inv_form && from_reg
		|=> flags == $past(flags) && operand == $past(operand) && pc == $past(pc) && refused_flag)
		else $error("inverting form with register bit number not refused");
	load_carry_a: assert property (exec_ok && !is_branch && op == carry_branch_pkg::load_bit_into_carry
		|=> flags.c == $past(bitv) && flags[3:1] == $past(flags[3:1])) else $error("bit load wrong");
	load_inv_a: assert property (exec_ok && !is_branch && op == carry_branch_pkg::load_inverted_bit_into_carry
		|=> flags.c == ~$past(bitv)) else $error("inverted bit load wrong");
	store_bit_a: assert property (exec_ok && !is_branch && op == carry_branch_pkg::store_carry_into_bit
		|=> ((operand ^ $past(operand)) & ~$past(bit_mask)) == 8'h00
		&& ((operand & $past(bit_mask)) != 8'h00) == $past(flags.c)) else $error("bit store wrong");
	store_inv_a: assert property (exec_ok && !is_branch && op == carry_branch_pkg::store_inverted_carry_into_bit
		|=> ((operand & $past(bit_mask)) != 8'h00) == ~$past(flags.c)) else $error("inverted bit store wrong");
	branch_pc_a: assert property (exec_ok && is_branch
		|=> pc == ($past(cond_true) ? $past(rel_target) : $past(next_pc)) && taken == $past(cond_true))
		else $error("branch target wrong");
	reg_bitnum_a: assert property (exec_ok && from_reg && !is_branch && op == carry_branch_pkg::load_bit_into_carry
		|=> flags.c == $past(operand[bitreg])) else $error("register bit number not used");
	call_return_a: assert property (exec_ok && !is_branch && op == carry_branch_pkg::absolute_subroutine_call
		|=> ret_addr == $past(next_pc) && pc == $past(target)) else $error("call wrong");
	return_pc_a: assert property (exec_ok && !is_branch && op == carry_branch_pkg::subroutine_return
		|=> pc == $past(ret_addr)) else $error("return wrong");

	branch_taken_c: cover property (exec_ok && is_branch && cond_true);
	branch_skip_c: cover property (exec_ok && is_branch && !cond_true);
	refused_c: cover property (exec && refused);
	call_then_ret_c: cover property (exec_ok && op == carry_branch_pkg::absolute_subroutine_call && !is_branch
		##[1:20] exec_ok && op == carry_branch_pkg::subroutine_return && !is_branch);
endmodule
`default_nettype wire

/* File: carry_bit_ops_branch_cond_tb_top.sv */
`default_nettype none
module carry_bit_ops_branch_cond_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int STEP = 2;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, last_err;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, last_rd;
	int num_errors, checked, cycles;
	carry_bit_ops_branch_cond #(.INSN_BYTES(STEP)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr));
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	task automatic results();
		$display("errors %0d checks %0d", num_errors, checked);
		if (num_errors == 0 && checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// hang guard, far above the expected run length
	always @(posedge pclk) begin
		cycles = cycles + 1;
		if (cycles == 60000) begin
			num_errors = num_errors + 1;
			$display("[ERR] %0t timeout", $time);
			results();
		end
	end
	task automatic check_word(input logic [31:0] got, input logic [31:0] exp, input string msg);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask
	task automatic check_flag(input logic got, input logic exp, input string msg);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %0t %s got %b exp %b", $time, msg, got, exp);
		end
	endtask
	// one apb transfer: setup, access held until pready at a rising edge
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		penable <= 1'b0;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		check_flag(pready, 1'b1, "pready");
		last_rd = prdata;
		last_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd_check(input logic [7:0] a, input logic [31:0] exp, input string msg);
		xfer(1'b0, a, 32'h0000_0000);
		check_word(last_rd, exp, msg);
	endtask
	task automatic scen_reset();
		for (int a = 0; a < 32; a += 4) begin
			rd_check(8'(a), 32'h0000_0000, "reset value");
			check_flag(last_err, 1'b0, "mapped pslverr");
		end
	endtask
	task automatic scen_bit_ops();
		logic [7:0] opnd, expo;
		logic [2:0] b;
		logic c, fr, sel, expc;
		opnd = 8'h5a;
		for (int op = 0; op < 6; op++) begin
			for (int k = 0; k < 32; k++) begin
				b = k[2:0];
				c = k[3];
				fr = k[4] & ~op[0];
				sel = opnd[b];
				expc = (op == 0) ? c ^ sel : (op == 1) ? c ^ ~sel : (op == 2) ? sel : (op == 3) ? ~sel : c;
				expo = opnd;
				if (op >= 4) begin
					expo[b] = (op == 4) ? c : ~c;
				end
				xfer(1'b1, carry_branch_pkg::OFF_FLAGS, {31'h0, c});
				xfer(1'b1, carry_branch_pkg::OFF_OPERAND, {24'h0, opnd});
				xfer(1'b1, carry_branch_pkg::OFF_BITREG, {29'h0, b});
				xfer(1'b1, carry_branch_pkg::OFF_CTRL, {23'h0, fr, fr ? ~b : b, 5'(op)});
				rd_check(carry_branch_pkg::OFF_FLAGS, {31'h0, expc}, "carry");
				rd_check(carry_branch_pkg::OFF_OPERAND, {24'h0, expo}, "operand");
				opnd = {opnd[6:0], opnd[7] ^ opnd[3]};
			end
		end
	endtask
	task automatic scen_refused();
		for (int op = 1; op < 6; op += 2) begin
			xfer(1'b1, carry_branch_pkg::OFF_FLAGS, 32'h0000_0001);
			xfer(1'b1, carry_branch_pkg::OFF_OPERAND, 32'h0000_00ff);
			xfer(1'b1, carry_branch_pkg::OFF_PC, 32'h0000_0040);
			xfer(1'b1, carry_branch_pkg::OFF_CTRL, 32'h0000_0100 | 32'(op));
			rd_check(carry_branch_pkg::OFF_STATUS, 32'h0000_0002, "refused status");
			rd_check(carry_branch_pkg::OFF_FLAGS, 32'h0000_0001, "refused carry");
			rd_check(carry_branch_pkg::OFF_OPERAND, 32'h0000_00ff, "refused operand");
			rd_check(carry_branch_pkg::OFF_PC, 32'h0000_0040, "refused pc");
		end
		xfer(1'b1, carry_branch_pkg::OFF_STATUS, 32'h0000_0000);
		rd_check(carry_branch_pkg::OFF_STATUS, 32'h0000_0002, "status read only");
		xfer(1'b1, carry_branch_pkg::OFF_STATUS, 32'h0000_0000);
		xfer(1'b1, carry_branch_pkg::OFF_CTRL, 32'h0000_0006);
		xfer(1'b1, carry_branch_pkg::OFF_CTRL, 32'h0000_000a);
		rd_check(carry_branch_pkg::OFF_STATUS, 32'h0000_0002, "unknown op refused");
		rd_check(carry_branch_pkg::OFF_FLAGS, 32'h0000_0001, "unknown op carry");
	endtask
	function automatic logic cond_eval(input logic [3:0] cc, input logic [3:0] f);
		logic n, z, v, c;
		{n, z, v, c} = f;
		case (cc[3:1])
			3'd0: cond_eval = 1'b1;
			3'd1: cond_eval = c | z;
			3'd2: cond_eval = c;
			3'd3: cond_eval = z;
			3'd4: cond_eval = v;
			3'd5: cond_eval = n;
			3'd6: cond_eval = n ^ v;
			default: cond_eval = z | (n ^ v);
		endcase
		if (cc[3:1] != 3'd0) begin
			cond_eval = cond_eval ~^ cc[0];
		end else begin
			cond_eval = ~cc[0];
		end
	endfunction
	task automatic scen_branch();
		logic t;
		for (int cc = 0; cc < 16; cc++) begin
			for (int f = 0; f < 16; f++) begin
				t = cond_eval(4'(cc), 4'(f));
				xfer(1'b1, carry_branch_pkg::OFF_FLAGS, 32'(f));
				xfer(1'b1, carry_branch_pkg::OFF_PC, 32'h0000_0100);
				xfer(1'b1, carry_branch_pkg::OFF_TARGET, 32'h0000_0020);
				xfer(1'b1, carry_branch_pkg::OFF_CTRL, 32'h0000_0010 | 32'(cc));
				rd_check(carry_branch_pkg::OFF_PC, t ? 32'h0000_0122 : 32'h0000_0102, "branch pc");
				rd_check(carry_branch_pkg::OFF_STATUS, {31'h0, t}, "branch taken");
			end
		end
	endtask
	task automatic scen_jumps();
		xfer(1'b1, carry_branch_pkg::OFF_PC, 32'h0000_0200);
		xfer(1'b1, carry_branch_pkg::OFF_TARGET, 32'h0000_1000);
		xfer(1'b1, carry_branch_pkg::OFF_CTRL, 32'h0000_0006);
		rd_check(carry_branch_pkg::OFF_PC, 32'h0000_1000, "goto pc");
		rd_check(carry_branch_pkg::OFF_STATUS, 32'h0000_0001, "goto taken");
		xfer(1'b1, carry_branch_pkg::OFF_CTRL, 32'h0000_0007);
		rd_check(carry_branch_pkg::OFF_RET, 32'h0000_1002, "rel call ret");
		rd_check(carry_branch_pkg::OFF_PC, 32'h0000_2002, "rel call pc");
		xfer(1'b1, carry_branch_pkg::OFF_CTRL, 32'h0000_0009);
		rd_check(carry_branch_pkg::OFF_PC, 32'h0000_1002, "return pc");
		xfer(1'b1, carry_branch_pkg::OFF_CTRL, 32'h0000_0008);
		rd_check(carry_branch_pkg::OFF_RET, 32'h0000_1004, "abs call ret");
		rd_check(carry_branch_pkg::OFF_PC, 32'h0000_1000, "abs call pc");
	endtask
	task automatic scen_unmapped();
		xfer(1'b1, 8'h24, 32'hffff_ffff);
		check_flag(last_err, 1'b1, "unmapped write err");
		rd_check(8'h20, 32'h0000_0000, "unmapped read");
		check_flag(last_err, 1'b1, "unmapped read err");
		rd_check(8'h05, 32'h0000_0000, "misaligned read");
		check_flag(last_err, 1'b1, "misaligned err");
	endtask
	initial begin
		num_errors = 0;
		checked = 0;
		cycles = 0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		scen_reset();
		scen_bit_ops();
		scen_refused();
		scen_branch();
		scen_jumps();
		scen_unmapped();
		results();
	end
endmodule
`default_nettype wire
